// >>> include/pcicfg_pkg.sv
/*
 * Package for the configuration header register slice: dword indices, byte lanes,
 * reset values, fixed field values, carrier structs, tenure states and shared functions.
 * Assumes configuration accesses arrive as dword index, byte enables and write data.
 */
package pcicfg_pkg;

   // --------
   // Configuration dword indices (byte address is four times these)
   // --------
   localparam int         CFG_IDX_W            = 6;
   localparam logic [5:0] IDX_MISC_DW          = 6'h03;
   localparam logic [5:0] IDX_WINDOW_FIRST     = 6'h04;
   localparam logic [5:0] IDX_WINDOW_LAST      = 6'h09;
   localparam logic [5:0] IDX_BOARD_IDENT      = 6'h0B;
   localparam logic [5:0] IDX_CAP_DW           = 6'h0D;
   localparam logic [5:0] IDX_INT_DW           = 6'h0F;

   // --------
   // Byte lanes inside their dwords
   // --------
   localparam logic [1:0] LANE_TENURE          = 2'h1;
   localparam logic [1:0] LANE_HEADER_LAYOUT   = 2'h2;
   localparam logic [1:0] LANE_SELF_TEST       = 2'h3;
   localparam logic [1:0] LANE_CAP_PTR         = 2'h0;
   localparam logic [1:0] LANE_INT_ROUTE       = 2'h0;

   // --------
   // Reset and fixed values
   // --------
   localparam logic [7:0]  TENURE_RST          = 8'h00;
   localparam logic [7:0]  HEADER_LAYOUT_VAL   = 8'h00;
   localparam logic [7:0]  SELF_TEST_VAL       = 8'h00;
   localparam logic [7:0]  CAP_PTR_VAL         = 8'h40;
   localparam logic [7:0]  INT_ROUTE_RST       = 8'h00;
   localparam logic [15:0] BOARD_IDENT_RST     = 16'h0000;
   localparam logic [27:0] WINDOW_ADDR_RST     = 28'h0000000;
   localparam logic [1:0]  WINDOW_TYPE_VAL     = 2'h0;
   localparam logic        WINDOW_SPACE_VAL    = 1'b0;
   localparam int          WINDOW_COUNT        = 6;
   localparam int          WINDOW_ADDR_LSB     = 4;
   localparam int          WINDOW_PREFETCH_BIT = 3;
   localparam logic [7:0]  TENURE_COUNT_MAX    = 8'hFF;

   // --------
   // Carriers and states
   // --------
   typedef struct packed {
      logic                 write;
      logic [CFG_IDX_W-1:0] index;
      logic [3:0]           byte_en;
      logic [31:0]          wdata;
   } pcicfg_req_type;

   typedef struct packed {
      logic        ack;
      logic        hit;
      logic [31:0] rdata;
   } pcicfg_rsp_type;

   typedef enum logic [1:0] {
      TEN_IDLE      = 2'b00,
      TEN_GRANTED   = 2'b01,
      TEN_WITHDRAWN = 2'b11,
      TEN_RELEASE   = 2'b10
   } pcicfg_tenure_state_type;

   // Picks one byte lane of a write, keeping the old byte when its enable is low
   function automatic logic [7:0] pcicfg_lane_merge(input logic [7:0]  old_byte,
                                                    input logic [31:0] wdata,
                                                    input logic [3:0]  byte_en,
                                                    input logic [1:0]  lane);
      pcicfg_lane_merge = byte_en[lane] ? wdata[8*lane +: 8] : old_byte;
   endfunction

   function automatic logic [7:0] pcicfg_lane_pick(input logic [31:0] wdata,
                                                   input logic [1:0]  lane);
      pcicfg_lane_pick = wdata[8*lane +: 8];
   endfunction

endpackage

// >>> hdl/pcicfg_byte_reg.sv
/*
 * One host-writable configuration byte with a lane write and an asynchronous reset value.
 * Assumes the caller decodes the dword and hands over the lane enable.
 */
`timescale 1ns/100ps
module pcicfg_byte_reg
   import pcicfg_pkg::*;
#(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       write_en,
   input  wire logic [7:0] write_byte,
   output logic      [7:0] value
);

   logic [7:0] value_r;

   // Only hardware reset returns the byte to its reset value
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         value_r <= RESET_VALUE;
      end else if (write_en) begin
         value_r <= write_byte;
      end
   end

   assign value = value_r;

endmodule // pcicfg_byte_reg

// >>> hdl/pcicfg_window_base.sv
/*
 * One memory window base register: masked address bits, mirrored prefetch bit,
 * hardwired type and space bits. Assumes mask and prefetch come from the mask register.
 */
`timescale 1ns/100ps
module pcicfg_window_base
   import pcicfg_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        write_en,
   input  wire logic [3:0]  byte_en,
   input  wire logic [31:0] wdata,
   input  wire logic [27:0] addr_mask,
   input  wire logic        prefetchable_enable,
   output logic      [31:0] value
);

   logic [27:0] addr_r;
   logic [27:0] lane_mask;

   // Byte enables narrowed onto the 28 address bits (bits 31..4)
   assign lane_mask = {{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {4{byte_en[0]}}};

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_r <= WINDOW_ADDR_RST;
      end else if (write_en) begin
         addr_r <= (addr_r & ~(addr_mask & lane_mask))
                 | (wdata[31:WINDOW_ADDR_LSB] & addr_mask & lane_mask);
      end
   end

   // Low nibble is never stored, so writes to it vanish silently
   assign value = {addr_r,
                   prefetchable_enable,
                   WINDOW_TYPE_VAL,
                   WINDOW_SPACE_VAL};

endmodule // pcicfg_window_base

// >>> hdl/pcicfg_header_regs.sv
/*
 * Configuration header register slice of a bus target:
 * bus tenure timer and its master tenure supervisor,
 * header layout, self-test, six memory window bases,
 * board identifiers, capability pointer and interrupt routing byte.
 * Assumes one access per request in the core clock domain,
 * and that the master engine reports its own frame and ownership.
 */
// Function
// - With grant withdrawn, release bus once cycles since frame reach timer.
// - While grant stays asserted, the timer never ends the transaction.
// - Tenure timer is read/write and clears to zero on hardware reset.
// - Software reset leaves the tenure timer contents unchanged.
// - Header layout byte is read-only and reads zero.
// - Self-test byte is read-only and always reads zero.
// - Window base bits 31..4 writable where mask allows; reset to zero.
// - Window base bit 3 read-only, mirrors the prefetchable enable.
// - Window base bits 2..1 read zero: 32-bit decoder only.
// - Window base bit 0 reads zero: memory space only.
// - Board product identifier is read-only, value set by board maker.
// - Board maker identifier is read-only, value set by board maker.
// - Capability pointer is read-only and returns 40h.
// - Host writes interrupt routing byte; device stores and returns it.
`timescale 1ns/100ps
module pcicfg_header_regs
   import pcicfg_pkg::*;
(
   input  wire logic                          core_clk,
   input  wire logic                          reset_n,
   input  wire logic                          soft_reset,

   input  wire logic                          cfg_valid,
   input  wire pcicfg_req_type                cfg_req,
   output pcicfg_rsp_type                     cfg_rsp,

   input  wire logic [WINDOW_COUNT-1:0][27:0] window_mask_register,
   input  wire logic [WINDOW_COUNT-1:0]       prefetchable_enable,

   input  wire logic [15:0]                   board_product_code,
   input  wire logic [15:0]                   board_maker_code,

   input  wire logic                          master_owner,
   input  wire logic                          cycle_frame_pin_n,
   input  wire logic                          bus_grant_input_n,

   output logic                               tenure_release,
   output logic [7:0]                         bus_tenure_count,
   output logic [7:0]                         interrupt_routing
);

   // --------
   // Access decode
   // --------
   logic                          wr_stb;
   logic                          wr_misc;
   logic                          wr_int;
   logic [WINDOW_COUNT-1:0]       wr_window;

   logic [7:0]                    tenure_wbyte;
   logic [7:0]                    route_wbyte;

   logic [7:0]                    tenure_value;
   logic [7:0]                    route_value;
   logic [WINDOW_COUNT-1:0][31:0] window_value;

   // Window dwords form one contiguous run of indices
   function automatic logic in_window_run(input logic [CFG_IDX_W-1:0] idx);
      in_window_run = (idx >= IDX_WINDOW_FIRST) && (idx <= IDX_WINDOW_LAST);
   endfunction


   assign wr_stb  = cfg_valid && cfg_req.write;
   assign wr_misc = wr_stb && (cfg_req.index == IDX_MISC_DW)
                    && cfg_req.byte_en[LANE_TENURE];
   assign wr_int  = wr_stb && (cfg_req.index == IDX_INT_DW)
                    && cfg_req.byte_en[LANE_INT_ROUTE];

   always_comb begin
      for (int i = 0; i < WINDOW_COUNT; i++) begin
         wr_window[i] = wr_stb
                        && (cfg_req.index == (IDX_WINDOW_FIRST + CFG_IDX_W'(i)));
      end
   end

   // --------
   // Write lanes
   // --------
   // Lanes other than the writable ones are dropped here, so a write to the layout
   // or self-test bytes leaves no trace
   assign tenure_wbyte = pcicfg_lane_pick(cfg_req.wdata, LANE_TENURE);
   assign route_wbyte  = pcicfg_lane_pick(cfg_req.wdata, LANE_INT_ROUTE);

   // --------
   // Host-writable bytes
   // --------
   // Soft reset is deliberately not wired to the timer byte
   pcicfg_byte_reg #(
      .RESET_VALUE (TENURE_RST)
   ) u_tenure_timer (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .write_en   (wr_misc),
      .write_byte (tenure_wbyte),
      .value      (tenure_value)
   );

   pcicfg_byte_reg #(
      .RESET_VALUE (INT_ROUTE_RST)
   ) u_int_routing (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .write_en   (wr_int),
      .write_byte (route_wbyte),
      .value      (route_value)
   );

   assign bus_tenure_count  = tenure_value;
   assign interrupt_routing = route_value;

   // --------
   // Memory window bases
   // --------
   generate
      for (genvar g = 0; g < WINDOW_COUNT; g++) begin : g_window
         pcicfg_window_base u_base (
            .core_clk            (core_clk),
            .reset_n             (reset_n),
            .write_en            (wr_window[g]),
            .byte_en             (cfg_req.byte_en),
            .wdata               (cfg_req.wdata),
            .addr_mask           (window_mask_register[g]),
            .prefetchable_enable (prefetchable_enable[g]),
            .value               (window_value[g])
         );
      end
   endgenerate

   // --------
   // Board identifiers
   // --------
   // Reset cannot load a port, so straps are taken on the first edge after release
   logic        ident_loaded_r;
   logic [15:0] board_product_r;
   logic [15:0] board_maker_r;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ident_loaded_r  <= 1'b0;
         board_product_r <= BOARD_IDENT_RST;
         board_maker_r   <= BOARD_IDENT_RST;
      end else if (!ident_loaded_r) begin
         ident_loaded_r  <= 1'b1;
         board_product_r <= board_product_code;
         board_maker_r   <= board_maker_code;
      end
   end

   // --------
   // Read mux
   // --------
   logic [31:0] rdata_nxt;
   logic        hit_nxt;

   always_comb begin
      rdata_nxt = 32'h00000000;
      hit_nxt   = 1'b1;

      case (cfg_req.index)
         IDX_MISC_DW: begin
            rdata_nxt[8*LANE_TENURE +: 8]        = tenure_value;
            rdata_nxt[8*LANE_HEADER_LAYOUT +: 8] = HEADER_LAYOUT_VAL;
            rdata_nxt[8*LANE_SELF_TEST +: 8]     = SELF_TEST_VAL;
         end

         IDX_BOARD_IDENT: begin
            rdata_nxt = {board_product_r, board_maker_r};
         end

         IDX_CAP_DW: begin
            rdata_nxt[8*LANE_CAP_PTR +: 8] = CAP_PTR_VAL;
         end

         IDX_INT_DW: begin
            rdata_nxt[8*LANE_INT_ROUTE +: 8] = route_value;
         end

         default: begin
            if (in_window_run(cfg_req.index)) begin
               rdata_nxt = window_value[3'(cfg_req.index - IDX_WINDOW_FIRST)];
            end else begin
               hit_nxt = 1'b0;
            end
         end
      endcase
   end

   // --------
   // Answer register
   // --------
   logic        ack_r;
   logic        hit_r;
   logic [31:0] rdata_r;

   // Answer one cycle after the request; other header bytes belong elsewhere,
   // so a miss is flagged rather than answered with data
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r   <= 1'b0;
         hit_r   <= 1'b0;
         rdata_r <= 32'h00000000;
      end else begin
         ack_r   <= cfg_valid;
         hit_r   <= cfg_valid && hit_nxt;

         if (cfg_valid && !cfg_req.write) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign cfg_rsp.ack   = ack_r;
   assign cfg_rsp.hit   = hit_r;
   assign cfg_rsp.rdata = rdata_r;

   // --------
   // Master tenure supervisor: frame edge
   // --------
   pcicfg_tenure_state_type ten_state_r;
   pcicfg_tenure_state_type ten_state_nxt;
   logic                    frame_prev_r;
   logic                    frame_start;
   logic [7:0]              tenure_cnt_r;
   logic                    tenure_spent;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_prev_r <= 1'b1;
      end else begin
         frame_prev_r <= cycle_frame_pin_n;
      end
   end

   // Counting begins on the cycle the device drives frame active
   assign frame_start  = master_owner && frame_prev_r && !cycle_frame_pin_n;

   // --------
   // Tenure counter
   // --------
   assign tenure_spent = (tenure_cnt_r >= tenure_value);

   // Saturates so a long tenure cannot wrap and look fresh again
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tenure_cnt_r <= 8'h00;
      end else if (soft_reset || frame_start) begin
         tenure_cnt_r <= 8'h00;
      end else if (ten_state_r != TEN_IDLE && tenure_cnt_r != TENURE_COUNT_MAX) begin
         tenure_cnt_r <= tenure_cnt_r + 8'h01;
      end
   end

   // --------
   // Tenure state
   // --------
   always_comb begin
      ten_state_nxt = ten_state_r;

      case (ten_state_r)
         TEN_IDLE: begin
            if (frame_start) begin
               ten_state_nxt = TEN_GRANTED;
            end
         end

         TEN_GRANTED: begin
            if (!master_owner) begin
               ten_state_nxt = TEN_IDLE;
            end else if (bus_grant_input_n) begin
               ten_state_nxt = TEN_WITHDRAWN;
            end
         end

         TEN_WITHDRAWN: begin
            if (!master_owner) begin
               ten_state_nxt = TEN_IDLE;
            end else if (tenure_spent) begin
               ten_state_nxt = TEN_RELEASE;
            end
         end

         TEN_RELEASE: begin
            if (!master_owner) begin
               ten_state_nxt = TEN_IDLE;
            end
         end

         default: begin
            ten_state_nxt = TEN_IDLE;
         end
      endcase
   end

   // Soft reset abandons any tenure in progress but never touches the timer byte
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ten_state_r <= TEN_IDLE;
      end else if (soft_reset) begin
         ten_state_r <= TEN_IDLE;
      end else begin
         ten_state_r <= ten_state_nxt;
      end
   end

   // --------
   // Release
   // --------
   // Grant withdrawal is a late event, so release holds until the master lets go
   assign tenure_release = (ten_state_r == TEN_RELEASE);

endmodule // pcicfg_header_regs

// >>> sim/pcicfg_header_regs_properties.sv
/* Checker for the header slice: answers, register lanes, tenure timing.
   Assumes the bind below; sees only top ports. */
`timescale 1ns/100ps
module pcicfg_header_regs_props
   import pcicfg_pkg::*;
(
   input wire logic                          core_clk,
   input wire logic                          reset_n,
   input wire logic                          soft_reset,
   input wire logic                          cfg_valid,
   input wire pcicfg_req_type                cfg_req,
   input wire pcicfg_rsp_type                cfg_rsp,
   input wire logic [WINDOW_COUNT-1:0]       prefetchable_enable,
   input wire logic                          master_owner,
   input wire logic                          cycle_frame_pin_n,
   input wire logic                          bus_grant_input_n,
   input wire logic                          tenure_release,
   input wire logic [7:0]                    bus_tenure_count,
   input wire logic [7:0]                    interrupt_routing
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // ------
   // Decode and tenure shadow
   // ------
   logic       rd_q, wr_q, win_idx, ten_wr, int_wr, win_rd, miss_idx, pf_sel, fs;
   logic       frame_q_r, started_r, held_r;
   logic [7:0] cyc_r;
   assign rd_q     = cfg_valid && !cfg_req.write;
   assign wr_q     = cfg_valid && cfg_req.write;
   assign win_idx  = cfg_req.index >= IDX_WINDOW_FIRST && cfg_req.index <= IDX_WINDOW_LAST;
   assign ten_wr   = wr_q && cfg_req.index == IDX_MISC_DW && cfg_req.byte_en[1];
   assign int_wr   = wr_q && cfg_req.index == IDX_INT_DW && cfg_req.byte_en[0];
   assign win_rd   = rd_q && win_idx;
   assign pf_sel   = prefetchable_enable[3'(cfg_req.index - IDX_WINDOW_FIRST)];
   assign miss_idx = !(win_idx || cfg_req.index == IDX_MISC_DW || cfg_req.index == IDX_INT_DW
                       || cfg_req.index == IDX_BOARD_IDENT || cfg_req.index == IDX_CAP_DW);
   assign fs       = master_owner && frame_q_r && !cycle_frame_pin_n;

   // Shadow of the supervisor count
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_q_r <= 1'b1;
         started_r <= 1'b0;
         held_r    <= 1'b0;
         cyc_r     <= 8'h00;
      end else begin
         frame_q_r <= cycle_frame_pin_n;
         started_r <= fs || (started_r && master_owner && !soft_reset);
         held_r    <= fs ? !bus_grant_input_n : (held_r && !bus_grant_input_n);
         cyc_r     <= fs ? 8'h00 : ((cyc_r == 8'hFF) ? cyc_r : cyc_r + 8'h01);
      end
   end

   ack_after_req_a: assert property (cfg_valid |=> cfg_rsp.ack)
      else $error("ack missing after request");
   ack_no_req_a: assert property (cfg_rsp.ack |-> $past(cfg_valid))
      else $error("ack without request");
   tenure_write_a: assert property (ten_wr |=> bus_tenure_count == $past(cfg_req.wdata[15:8]))
      else $error("tenure timer write lost");
   tenure_hold_a: assert property (!ten_wr |=> $stable(bus_tenure_count))
      else $error("tenure timer changed without write");
   route_write_a: assert property (int_wr |=> interrupt_routing == $past(cfg_req.wdata[7:0]))
      else $error("interrupt routing write lost");
   misc_read_a: assert property (rd_q && cfg_req.index == IDX_MISC_DW |=>
      cfg_rsp.rdata == {16'h0000, $past(bus_tenure_count), 8'h00})
      else $error("misc dword read wrong");
   cap_read_a: assert property (rd_q && cfg_req.index == IDX_CAP_DW |=>
      cfg_rsp.hit && cfg_rsp.rdata == 32'h00000040)
      else $error("capability pointer read wrong");
   window_low_a: assert property (win_rd |=> cfg_rsp.rdata[3:0] == {$past(pf_sel), 3'b000})
      else $error("window low bits wrong");
   miss_flag_a: assert property (cfg_valid && miss_idx |=> cfg_rsp.ack && !cfg_rsp.hit)
      else $error("unmapped index reported as hit");
   grant_held_a: assert property (held_r && master_owner |-> !tenure_release)
      else $error("release while grant held");
   release_due_a: assert property (started_r && master_owner && !soft_reset && bus_grant_input_n
      && $past(bus_grant_input_n) && cyc_r >= bus_tenure_count |-> ##[0:3] tenure_release)
      else $error("release late");
   release_drop_a: assert property (!master_owner |=> !tenure_release)
      else $error("release held after ownership ended");

   cover property ($rose(tenure_release));
   cover property (ten_wr);
   cover property (cfg_valid && miss_idx);
endmodule // pcicfg_header_regs_props

bind pcicfg_header_regs pcicfg_header_regs_props pcicfg_header_regs_props_i (
   .core_clk(core_clk), .reset_n(reset_n), .soft_reset(soft_reset), .cfg_valid(cfg_valid),
   .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
   .prefetchable_enable(prefetchable_enable), .master_owner(master_owner),
   .cycle_frame_pin_n(cycle_frame_pin_n), .bus_grant_input_n(bus_grant_input_n),
   .tenure_release(tenure_release), .bus_tenure_count(bus_tenure_count),
   .interrupt_routing(interrupt_routing));

// >>> sim/pcicfg_host_model.sv
/* Host issuing one configuration access per call.
   Assumes the answer is registered on the taking edge and read just after it. */
`timescale 1ns/100ps
module pcicfg_host_model
   import pcicfg_pkg::*;
(
   input  wire logic           core_clk,
   output logic                cfg_valid,
   output pcicfg_req_type      cfg_req,
   input  wire pcicfg_rsp_type cfg_rsp
);
   initial begin
      cfg_valid = 1'b0;
      cfg_req   = '0;
   end

   task automatic access(input logic wr, input logic [5:0] idx, input logic [3:0] be,
                         input logic [31:0] wd, output logic [31:0] rd, output logic hit,
                         output logic ack);
      @(posedge core_clk);
      cfg_valid <= 1'b1;
      cfg_req   <= '{wr, idx, be, wd};
      @(posedge core_clk);
      cfg_valid <= 1'b0;
      // Idle lines inverted so a stale copy never passes
      cfg_req   <= ~cfg_req;
      #1;
      rd  = cfg_rsp.rdata;
      hit = cfg_rsp.hit;
      ack = cfg_rsp.ack;
   endtask
endmodule // pcicfg_host_model

// >>> sim/tb.sv
/* Self-checking bench for the configuration header slice.
   Assumes the host model; the bench plays the master. */
`timescale 1ns/100ps
module tb;
   import pcicfg_pkg::*;
   localparam logic [15:0] PRODUCT_STRAP = 16'h5A3C; // Arbitrary value
   localparam logic [5:0]  PF_SET        = 6'b101001;
   logic                          core_clk, reset_n, soft_reset, cfg_valid, hit, ack;
   logic                          master_owner, cycle_frame_pin_n, bus_grant_input_n;
   logic                          tenure_release;
   logic [7:0]                    bus_tenure_count, interrupt_routing;
   logic [31:0]                   rd;
   logic [WINDOW_COUNT-1:0][27:0] window_mask_register;
   logic [WINDOW_COUNT-1:0]       prefetchable_enable;
   pcicfg_req_type                cfg_req;
   pcicfg_rsp_type                cfg_rsp;
   int                            fail_count, samples_checked;

   pcicfg_header_regs pcicfg_header_regs_i (.core_clk(core_clk), .reset_n(reset_n),
      .soft_reset(soft_reset), .cfg_valid(cfg_valid), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
      .window_mask_register(window_mask_register), .prefetchable_enable(prefetchable_enable),
      .board_product_code(PRODUCT_STRAP), .board_maker_code(16'h0000),
      .master_owner(master_owner), .cycle_frame_pin_n(cycle_frame_pin_n),
      .bus_grant_input_n(bus_grant_input_n), .tenure_release(tenure_release),
      .bus_tenure_count(bus_tenure_count), .interrupt_routing(interrupt_routing));
   pcicfg_host_model pcicfg_host_model_i (.core_clk(core_clk), .cfg_valid(cfg_valid),
      .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));

   // ------
   // Checking and access helpers
   // ------
   task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd_chk(input string what, input logic [5:0] idx, input logic [31:0] exp);
      pcicfg_host_model_i.access(1'b0, idx, 4'hF, 32'h00000000, rd, hit, ack);
      check32({what, " ack hit"}, 32'h00000003, {30'h0, ack, hit});
      check32(what, exp, rd);
   endtask

   task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
      pcicfg_host_model_i.access(1'b1, idx, be, wd, rd, hit, ack);
      check32("write ack", 32'h00000001, {31'h0, ack});
   endtask

   task automatic print_verdict();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ------
   // Scenarios
   // ------
   task automatic t_reset_values();
      rd_chk("misc", IDX_MISC_DW, 32'h00000000);
      for (int i = 0; i < WINDOW_COUNT; i++)
         rd_chk("window", IDX_WINDOW_FIRST + 6'(i), {28'h0, PF_SET[i], 3'b000});
      rd_chk("ident", IDX_BOARD_IDENT, {PRODUCT_STRAP, 16'h0000});
      rd_chk("cap", IDX_CAP_DW, 32'h00000040);
      rd_chk("route", IDX_INT_DW, 32'h00000000);
   endtask

   task automatic t_rw_lanes();
      wr(IDX_MISC_DW, 4'hF, 32'hFFFFA5FF);
      rd_chk("misc", IDX_MISC_DW, 32'h0000A500);
      check32("timer port", 32'h000000A5, {24'h0, bus_tenure_count});
      wr(IDX_MISC_DW, 4'hD, 32'h00003C00);
      rd_chk("misc lane off", IDX_MISC_DW, 32'h0000A500);
      @(posedge core_clk);
      soft_reset <= 1'b1;
      @(posedge core_clk);
      soft_reset <= 1'b0;
      rd_chk("misc after soft", IDX_MISC_DW, 32'h0000A500);
      wr(IDX_INT_DW, 4'hF, 32'hFFFFFF7E);
      rd_chk("route", IDX_INT_DW, 32'h0000007E);
      check32("route port", 32'h0000007E, {24'h0, interrupt_routing});
      wr(IDX_BOARD_IDENT, 4'hF, 32'hFFFFFFFF);
      wr(IDX_CAP_DW, 4'hF, 32'hFFFFFFFF);
      rd_chk("ident", IDX_BOARD_IDENT, {PRODUCT_STRAP, 16'h0000});
      rd_chk("cap", IDX_CAP_DW, 32'h00000040);
      pcicfg_host_model_i.access(1'b0, 6'h3F, 4'hF, 32'h00000000, rd, hit, ack);
      check32("miss ack hit", 32'h00000002, {30'h0, ack, hit});
      check32("miss data", 32'h00000000, rd);
   endtask

   task automatic t_windows();
      logic [5:0] idx;
      for (int i = 0; i < WINDOW_COUNT; i++) begin
         idx = IDX_WINDOW_FIRST + 6'(i);
         wr(idx, 4'hF, 32'hFFFFFFFF);
         rd_chk("window ones", idx, {window_mask_register[i], PF_SET[i], 3'b000});
         wr(idx, 4'hE, 32'h00000000);
         rd_chk("window part", idx, {window_mask_register[i] & 28'h000000F, PF_SET[i],
                3'b000});
      end
   endtask

   task automatic t_tenure(input logic [7:0] t);
      int n;
      wr(IDX_MISC_DW, 4'h2, {16'h0000, t, 8'h00});
      n = 0;
      @(posedge core_clk);
      master_owner      <= 1'b1;
      cycle_frame_pin_n <= 1'b0;
      repeat (20) begin
         @(posedge core_clk);
         #1;
         if (tenure_release !== 1'b0) n++;
      end
      check32("release with grant held", 32'h0, n);
      @(posedge core_clk);
      master_owner      <= 1'b0;
      cycle_frame_pin_n <= 1'b1;
      @(posedge core_clk);
      master_owner      <= 1'b1;
      cycle_frame_pin_n <= 1'b0;
      @(posedge core_clk);
      bus_grant_input_n <= 1'b1;
      n = 0;
      while (tenure_release !== 1'b1 && n < 300) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      // One to three edges to see the grant go
      check32("release delay", 32'h1, {31'h0, n >= t + 1 && n <= t + 3});
      @(posedge core_clk);
      master_owner      <= 1'b0;
      cycle_frame_pin_n <= 1'b1;
      bus_grant_input_n <= 1'b0;
      @(posedge core_clk);
      #1;
      check32("release drop", 32'h0, {31'h0, tenure_release});
   endtask

   task automatic t_hw_reset();
      @(posedge core_clk);
      reset_n <= 1'b0;
      @(posedge core_clk);
      reset_n <= 1'b1;
      rd_chk("misc after reset", IDX_MISC_DW, 32'h00000000);
      rd_chk("window after reset", IDX_WINDOW_FIRST, {28'h0, PF_SET[0], 3'b000});
   endtask

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   initial begin
      #1000000;
      fail_count++;
      print_verdict();
   end

   initial begin
      reset_n           = 1'b0;
      soft_reset        = 1'b0;
      master_owner      = 1'b0;
      cycle_frame_pin_n = 1'b1;
      bus_grant_input_n = 1'b0;
      prefetchable_enable = PF_SET;
      for (int i = 0; i < WINDOW_COUNT; i++)
         window_mask_register[i] = 28'hFFFFFFF << (4 * i);
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      t_reset_values();
      t_rw_lanes();
      t_windows();
      t_tenure(8'h02);
      t_tenure(8'h00);
      t_hw_reset();
      print_verdict();
   end
endmodule // tb
